// ===== bench/cflsc_chk.sv
// port-level assertions for the run-state controller
`timescale 1ns/1ps
`default_nettype none
module cflsc_chk (
  input wire logic ref_clk, resetn, svc_exec, breakpoint_instr_exec, dbg_attached, ldst_bus_err, xn_fetch,
  input wire logic fetch_bus_err, vect_bus_err, undef_instr, state_bit_clr, unaligned_ldst,
  input wire logic unstack_err, ret_main_sp, wfe_exec, ext_event, irq_pend, nmi_req, dbg_halt,
  input wire logic [7:0] cur_prio, svc_prio,
  input wire cflsc_pkg::cflsc_ctx_t exec_ctx,
  input wire logic fault_take_q, nmi_take_q, core_run_q, wake_q, lockup_q, sleeping_q, deep_sleep_q
);
  import cflsc_pkg::*;
  // any fault source this cycle
  wire logic af = (svc_exec && cur_prio <= svc_prio) || (breakpoint_instr_exec && !dbg_attached) || ldst_bus_err
    || xn_fetch || fetch_bus_err || vect_bus_err || undef_instr || state_bit_clr || unaligned_ldst;
  logic lfh_q, wfe_q;
  // cause of lockup and of sleep, frozen while in that state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lfh_q <= 1'b0;
      wfe_q <= 1'b0;
    end else begin
      if (!lockup_q) lfh_q <= exec_ctx == CFLSC_CTX_FAULT && !unstack_err;
      if (!sleeping_q) wfe_q <= wfe_exec;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  fault_take_a: assert property (af && core_run_q && exec_ctx inside {CFLSC_CTX_THREAD, CFLSC_CTX_HANDLER}
    |=> fault_take_q) else $error("fault not taken");
  no_spur_a: assert property (fault_take_q |-> $past(af) && $past(core_run_q)) else $error("spurious fault");
  fault_lock_a: assert property (af && core_run_q && exec_ctx inside {CFLSC_CTX_FAULT, CFLSC_CTX_NMI}
    |=> lockup_q && !fault_take_q) else $error("no lockup");
  unstack_lock_a: assert property (unstack_err && ret_main_sp && core_run_q |=> lockup_q) else $error("unstack");
  lock_idle_a: assert property (lockup_q |-> !core_run_q && !sleeping_q) else $error("runs in lockup");
  lock_hold_a: assert property (lockup_q && !lfh_q && !dbg_halt |=> lockup_q) else $error("left lockup");
  nmi_exit_a: assert property (lockup_q && lfh_q && nmi_req && !dbg_halt
    |=> !lockup_q && nmi_take_q) else $error("nmi exit");
  halt_exit_a: assert property (lockup_q && dbg_halt |=> !lockup_q && core_run_q) else $error("halt exit");
  deep_sleep_a: assert property (deep_sleep_q |-> sleeping_q && !core_run_q) else $error("deep sleep");
  wfi_stay_a: assert property (sleeping_q && !wfe_q && !nmi_req && !irq_pend && !dbg_halt
    |=> sleeping_q) else $error("woke early");
  evt_wake_a: assert property (sleeping_q && wfe_q && ext_event
    |=> !sleeping_q && wake_q && core_run_q) else $error("event wake");
  wake_once_a: assert property ($fell(sleeping_q) |-> wake_q ##1 !wake_q) else $error("wake pulse");
  cover property (lockup_q ##1 !lockup_q);
  cover property ($rose(deep_sleep_q));
  cover property (wfe_q && wake_q);
endmodule : cflsc_chk
`default_nettype wire

// ===== bench/cflsc_evt_model.sv
// event controller model: edge-detects enabled source lines onto the event input
`timescale 1ns/1ps
`default_nettype none
module cflsc_evt_model (
  input  wire logic        ref_clk,   // core clock
  input  wire logic        resetn,    // async reset, active low
  input  wire logic [15:0] src,       // external source lines
  input  wire logic [15:0] en,        // per-line event enable
  output logic             ext_event  // event input of the core
);
  logic [15:0] prev_q;
  // one-cycle event when any enabled line is newly raised
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q    <= '0;
      ext_event <= 1'b0;
    end else begin
      prev_q    <= src;
      ext_event <= |(src & ~prev_q & en);
    end
  end
endmodule : cflsc_evt_model
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the run-state controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cflsc_pkg::*;
  logic ref_clk = 0, resetn = 0, d;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  cflsc_ctx_t exec_ctx = CFLSC_CTX_THREAD;
  logic [7:0] cur_prio = '0, svc_prio = '0, irq_prio = '0;
  logic dbg_attached = 0, ret_main_sp = 0, irq_pend = 0, irq_enabled = 1, ext_event;
  logic svc_exec, breakpoint_instr_exec, ldst_bus_err, xn_fetch, fetch_bus_err, vect_bus_err, undef_instr, state_bit_clr;
  logic unaligned_ldst, wfi_exec, wfe_exec, sev_exec, ret_to_thread, dbg_halt, irq_new_pend, unstack_err, nmi_req;
  logic fault_take_q, nmi_take_q, irq_take_q, core_run_q, wake_q, lockup_q, sleeping_q, deep_sleep_q;
  logic [16:0] pv = '0;
  logic [15:0] src = '0, en = '0;
  int miscompares = 0, cmp_count = 0, b;
  // pulse inputs of the core group, one bit each
  assign {svc_exec, breakpoint_instr_exec, ldst_bus_err, xn_fetch, fetch_bus_err, vect_bus_err, undef_instr, state_bit_clr,
    unaligned_ldst, wfi_exec, wfe_exec, sev_exec, ret_to_thread, dbg_halt, irq_new_pend, unstack_err, nmi_req} = pv;
  cflsc_top dut (.*);
  cflsc_evt_model u_evt (.ref_clk, .resetn, .src, .en, .ext_event);
  initial forever #25 ref_clk = ~ref_clk;
  initial begin
    #(50 * 6000);
    miscompares++;
    report_and_stop();
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic exp_fault(input int b, input logic [7:0] c, s, input logic at);
    return b == 16 ? c <= s : b == 15 ? !at : 1'b1;
  endfunction : exp_fault
  task automatic pulse(input int b);
    @(posedge ref_clk);
    pv[b] <= 1'b1;
    @(posedge ref_clk);
    pv[b] <= 1'b0;
    #1;
  endtask : pulse
  task automatic evt();
    int k;
    k = $urandom % 16;
    @(posedge ref_clk);
    en <= 16'($urandom) | (16'h1 << k);
    src[k] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    src <= '0;
    #1;
  endtask : evt
  task automatic wr(input logic [3:0] a, input logic [31:0] x, input logic [3:0] s, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    fork
      begin do @(posedge ref_clk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge ref_clk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask : rd
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // main sequence: registers, faults, lockup, sleep and wake
  initial begin
    void'($urandom(32'h517328d3));
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    chk("run", 1, core_run_q);
    rd(CFLSC_CTRL_OFS, 0, CFLSC_RESP_OKAY);
    v = $urandom;
    wr(CFLSC_CTRL_OFS, v, 4'hf, CFLSC_RESP_OKAY);
    wr(CFLSC_CTRL_OFS, ~v, 4'he, CFLSC_RESP_OKAY);
    rd(CFLSC_CTRL_OFS, v & 32'hf, CFLSC_RESP_OKAY);
    wr(CFLSC_STAT_OFS, '1, 4'hf, CFLSC_RESP_OKAY);
    rd(CFLSC_STAT_OFS, 0, CFLSC_RESP_OKAY);
    wr(4'h8, v, 4'hf, CFLSC_RESP_SLVERR);
    rd(4'hc, 0, CFLSC_RESP_SLVERR);
    wr(CFLSC_CTRL_OFS, 0, 4'hf, CFLSC_RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 27; i++) begin
      b = 8 + i % 9;
      cur_prio <= 8'($urandom);
      svc_prio <= 8'($urandom);
      dbg_attached <= 1'($urandom);
      exec_ctx <= cflsc_ctx_t'($urandom % 2);
      pulse(b);
      chk("fault_take", exp_fault(b, cur_prio, svc_prio, dbg_attached), fault_take_q);
    end
    $display("test faults done");
    for (int k = 0; k < 2; k++) begin
      exec_ctx <= k ? CFLSC_CTX_NMI : CFLSC_CTX_FAULT;
      pulse(8 + $urandom % 7);
      chk("lockup", 1, lockup_q);
      chk("fault_take", 0, fault_take_q);
      rd(CFLSC_STAT_OFS, k ? 1 : 9, CFLSC_RESP_OKAY);
      pulse(7);
      chk("lock_sleep", 0, sleeping_q);
      pulse(0);
      chk("lock_nmi", k, lockup_q);
      chk("nmi_take", !k, nmi_take_q);
      pulse(3);
      chk("lock_halt", 0, lockup_q);
    end
    exec_ctx <= CFLSC_CTX_THREAD;
    ret_main_sp <= 1'b1;
    pulse(1);
    chk("unstack", 1, lockup_q);
    pulse(3);
    $display("test lockup done");
    d = 1'($urandom);
    wr(CFLSC_CTRL_OFS, {28'h0, 3'h4, d}, 4'hf, CFLSC_RESP_OKAY);
    irq_prio <= 8'h40;
    irq_pend <= 1'b1;
    pulse(7);
    chk("wfi_pending", 0, sleeping_q);
    chk("irq_masked", 0, irq_take_q);
    irq_pend <= 1'b0;
    pulse(7);
    chk("wfi_sleep", 1, sleeping_q);
    chk("deep", d, deep_sleep_q);
    evt();
    chk("wfi_evt", 1, sleeping_q);
    irq_pend <= 1'b1;
    pulse(2);
    chk("irq_wake", 0, sleeping_q);
    chk("irq_masked", 0, irq_take_q);
    wr(CFLSC_CTRL_OFS, 0, 4'hf, CFLSC_RESP_OKAY);
    #1 chk("irq_take", 1, irq_take_q);
    irq_pend <= 1'b0;
    pulse(5);
    pulse(6);
    chk("wfe_set", 0, sleeping_q);
    pulse(6);
    chk("wfe_clr", 1, sleeping_q);
    pulse(2);
    chk("no_eop", 1, sleeping_q);
    evt();
    chk("evt_wake", 1, wake_q);
    evt();
    pulse(6);
    chk("awake_evt", 0, sleeping_q);
    pulse(6);
    wr(CFLSC_CTRL_OFS, 4, 4'hf, CFLSC_RESP_OKAY);
    {irq_pend, irq_enabled} <= 2'h2;
    pulse(2);
    chk("eop_wake", 0, sleeping_q);
    wr(CFLSC_CTRL_OFS, 2, 4'hf, CFLSC_RESP_OKAY);
    pulse(4);
    chk("after_handler", 1, sleeping_q);
    pulse(0);
    chk("nmi_wake", 0, sleeping_q);
    $display("test sleep done");
    report_and_stop();
  end
endmodule : tb_top
bind cflsc_top cflsc_chk u_chk (.*);
`default_nettype wire

// ===== rtl/cflsc_event_latch.sv
// one-bit hidden wait-for-event latch
`timescale 1ns/1ps
`default_nettype none
module cflsc_event_latch (
  input  wire logic ref_clk,   // core clock
  input  wire logic resetn,    // async reset, active low
  input  wire logic set_evt,   // set request
  input  wire logic clr_evt,   // clear request
  output logic      latch_q    // latch value
);
  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= 1'b0;
    end else if (set_evt) begin
      latch_q <= 1'b1;
    end else if (clr_evt) begin
      latch_q <= 1'b0;
    end
  end
endmodule : cflsc_event_latch
`default_nettype wire

// ===== rtl/cflsc_pkg.sv
// constants and types for the fault, lockup and sleep run-state controller
// Notes on behaviour
// RQ1 - each fault takes escalated fault, but locks up inside nmi or fault handler
// RQ2 - fault on supervisor call at too high priority, unattached breakpoint, load/store bus error
// RQ3 - fault on execute-never fetch, fetch bus error, vector error, undefined, state bit, unaligned
// RQ4 - escalated fault preempts all but reset, nmi and itself; only those preempt it
// RQ5 - bus error unstacking status word on main stack return causes lockup
// RQ6 - in lockup no instruction is fetched or executed until a permitted exit
// RQ7 - lockup ends on reset or debugger halt, or nmi if locked in fault handler
// RQ8 - lockup from the nmi handler is not released by another nmi
// RQ9 - sleep stops only the core clock; deep sleep requests most clocks stopped
// RQ10 - deep sleep select bit chooses ordinary or deep sleep on entry; here deep_sleep_q follows the bit on every cycle of sleep
// RQ11 - wait for interrupt sleeps at once unless a wakeup is already true
// RQ12 - wait for event: latch 0 sleeps, latch 1 is cleared and execution continues
// RQ13 - event latch hidden from software, set by event input or send event
// RQ14 - sleep after handler enters sleep on return to thread mode
// RQ15 - wait-for-interrupt or after-handler sleep wakes only on a takeable exception
// RQ16 - with global mask set, a wake-worthy interrupt wakes but its handler is deferred
// RQ17 - wait-for-event sleep wakes on takeable exception or external event input
// RQ18 - event on pending: any newly pending interrupt wakes wait-for-event sleep
// RQ19 - the external controller drives the single event input from its sources
// RQ20 - event arriving while awake sets latch so next wait for event continues
// RQ21 - exception is takeable only if it beats the mask limit; otherwise it stays pending
// RQ22 - lockup, sleeping and deep sleep indicators are presented to the system
package cflsc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0]  CFLSC_CTRL_OFS   = 4'h0;
  localparam logic [3:0]  CFLSC_STAT_OFS   = 4'h4;
  localparam int          CFLSC_DS_BIT     = 0;
  localparam int          CFLSC_SAH_BIT    = 1;
  localparam int          CFLSC_EOP_BIT    = 2;
  localparam int          CFLSC_GIM_BIT    = 3;
  localparam int          CFLSC_LCK_BIT    = 0;
  localparam int          CFLSC_SLP_BIT    = 1;
  localparam int          CFLSC_DSLP_BIT   = 2;
  localparam int          CFLSC_LFH_BIT    = 3;
  localparam logic [3:0]  CFLSC_CTRL_RST   = 4'h0;
  localparam logic [1:0]  CFLSC_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  CFLSC_RESP_SLVERR = 2'h2;

  // execution context of the core
  typedef enum logic [1:0] {
    CFLSC_CTX_THREAD  = 2'b00,
    CFLSC_CTX_HANDLER = 2'b01,
    CFLSC_CTX_FAULT   = 2'b10,
    CFLSC_CTX_NMI     = 2'b11
  } cflsc_ctx_t;

  // run state of the core
  typedef enum logic [1:0] {
    CFLSC_ST_RUN    = 2'b00,
    CFLSC_ST_SLPINT = 2'b01,
    CFLSC_ST_SLPEVT = 2'b10,
    CFLSC_ST_LOCK   = 2'b11
  } cflsc_state_t;
endpackage : cflsc_pkg

// ===== rtl/cflsc_top.sv
// fault escalation, lockup and sleep control with axi4-lite registers
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cflsc_top (
  input  wire logic                 ref_clk,          // core clock
  input  wire logic                 resetn,           // async reset, active low
  // axi4-lite slave
  input  wire logic [3:0]           s_axi_awaddr,     // write address
  input  wire logic                 s_axi_awvalid,    // write address valid
  output logic                      s_axi_awready,    // write address ready
  input  wire logic [31:0]          s_axi_wdata,      // write data
  input  wire logic [3:0]           s_axi_wstrb,      // write strobes
  input  wire logic                 s_axi_wvalid,     // write data valid
  output logic                      s_axi_wready,     // write data ready
  output logic [1:0]                s_axi_bresp,      // write response
  output logic                      s_axi_bvalid,     // write response valid
  input  wire logic                 s_axi_bready,     // write response ready
  input  wire logic [3:0]           s_axi_araddr,     // read address
  input  wire logic                 s_axi_arvalid,    // read address valid
  output logic                      s_axi_arready,    // read address ready
  output logic [31:0]               s_axi_rdata,      // read data
  output logic [1:0]                s_axi_rresp,      // read response
  output logic                      s_axi_rvalid,     // read data valid
  input  wire logic                 s_axi_rready,     // read data ready
  // core status
  input  wire cflsc_pkg::cflsc_ctx_t exec_ctx,        // current execution context
  input  wire logic [7:0]           cur_prio,         // current execution priority
  input  wire logic [7:0]           svc_prio,         // supervisor call exception priority
  // fault sources, one-cycle pulses, with dbg_attached and ret_main_sp as level qualifiers
  input  wire logic                 svc_exec,         // supervisor call executed
  input  wire logic                 breakpoint_instr_exec,        // breakpoint executed
  input  wire logic                 dbg_attached,     // debugger attached
  input  wire logic                 ldst_bus_err,     // load/store bus error
  input  wire logic                 xn_fetch,         // fetch from execute-never address
  input  wire logic                 fetch_bus_err,    // fetch from bus-faulting location
  input  wire logic                 vect_bus_err,     // vector fetch bus error
  input  wire logic                 undef_instr,      // undefined instruction
  input  wire logic                 state_bit_clr,    // execution with state bit 0
  input  wire logic                 unaligned_ldst,   // unaligned load/store
  input  wire logic                 unstack_err,      // status word unstack bus error
  input  wire logic                 ret_main_sp,      // return uses main stack pointer
  // sleep and wake sources
  input  wire logic                 wfi_exec,         // wait for interrupt executed
  input  wire logic                 wfe_exec,         // wait for event executed
  input  wire logic                 sev_exec,         // send event in the system
  input  wire logic                 ret_to_thread,    // handler return to thread mode
  input  wire logic                 ext_event,        // external event input
  input  wire logic                 irq_pend,         // an interrupt is pending
  input  wire logic                 irq_enabled,      // pending interrupt is enabled
  input  wire logic [7:0]           irq_prio,         // pending interrupt priority
  input  wire logic                 irq_new_pend,     // interrupt newly became pending
  input  wire logic                 nmi_req,          // nonmaskable interrupt request
  input  wire logic                 dbg_halt,         // debugger halt request
  // outputs to core and system
  output logic                      fault_take_q,     // take escalated fault
  output logic                      nmi_take_q,       // take nonmaskable interrupt
  output logic                      irq_take_q,       // take pending interrupt
  output logic                      core_run_q,       // fetch and execute allowed
  output logic                      wake_q,           // wakeup pulse
  output logic                      lockup_q,         // lockup indicator
  output logic                      sleeping_q,       // core clock may stop
  output logic                      deep_sleep_q      // deep sleep request
);
  import cflsc_pkg::*;

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  logic [3:0]   ctrl_q;
  logic         lock_fh_q;
  logic         lock_fh_d;
  cflsc_state_t state_q;
  cflsc_state_t state_d;
  logic         evt_latch;
  logic         aw_got_q;
  logic         w_got_q;
  logic [3:0]   awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;

  wire ds_sel  = ctrl_q[CFLSC_DS_BIT];
  wire sah_sel = ctrl_q[CFLSC_SAH_BIT];
  wire eop_sel = ctrl_q[CFLSC_EOP_BIT];
  wire gim_sel = ctrl_q[CFLSC_GIM_BIT];

  // priority compare, lower value is more urgent
  function automatic logic cflsc_beats(input logic [7:0] a, input logic [7:0] b);
    cflsc_beats = (a < b);
  endfunction : cflsc_beats

  // ------------------------------------------------------------
  // fault detection and escalation
  // ------------------------------------------------------------
  // equal or more urgent than the supervisor call exception faults, in any context
  wire svc_fault  = svc_exec & (cur_prio <= svc_prio); // [RQ2]
  wire breakpoint_instr_fault = breakpoint_instr_exec & !dbg_attached; // [RQ2]
  wire fault_a    = svc_fault | breakpoint_instr_fault | ldst_bus_err; // [RQ2]
  wire fault_b    = xn_fetch | fetch_bus_err | vect_bus_err | undef_instr
                  | state_bit_clr | unaligned_ldst; // [RQ3]
  wire running    = (state_q == CFLSC_ST_RUN);
  wire any_fault  = running & (fault_a | fault_b);
  wire in_fixed   = (exec_ctx == CFLSC_CTX_NMI) | (exec_ctx == CFLSC_CTX_FAULT);
  wire fault_lock = any_fault & in_fixed; // [RQ1]
  wire fault_esc  = any_fault & !in_fixed; // [RQ1] [RQ4]
  wire unstk_lock = running & unstack_err & ret_main_sp; // [RQ5]
  wire enter_lock = fault_lock | unstk_lock;

  // lockup exits
  wire in_lock    = (state_q == CFLSC_ST_LOCK);
  wire nmi_unlock = in_lock & nmi_req & lock_fh_q; // [RQ7] [RQ8]
  wire exit_lock  = in_lock & (dbg_halt | nmi_unlock); // [RQ7]

  // nmi preempts everything but itself and a lockup entry in the same cycle; it ends a fault-handler lockup
  wire nmi_go     = nmi_req & ((running & (exec_ctx != CFLSC_CTX_NMI) & !enter_lock)
                  | nmi_unlock); // [RQ4]

  // ------------------------------------------------------------
  // exception sufficiency and wake conditions
  // ------------------------------------------------------------
  wire irq_beats  = irq_pend & irq_enabled
                  & ((exec_ctx == CFLSC_CTX_THREAD) | cflsc_beats(irq_prio, cur_prio)); // [RQ21]
  wire irq_go_ok  = irq_beats & !gim_sel;                                               // [RQ16] [RQ21]
  wire wake_exc   = irq_beats | nmi_req;                                                // [RQ15] [RQ16]
  wire wake_evt   = wake_exc | ext_event | (eop_sel & irq_new_pend);                    // [RQ17] [RQ18]

  // ------------------------------------------------------------
  // event latch control
  // ------------------------------------------------------------
  wire in_evt_slp = (state_q == CFLSC_ST_SLPEVT);
  wire evt_set    = (ext_event | sev_exec | (eop_sel & irq_new_pend)) & !in_evt_slp;   // [RQ13] [RQ20]
  wire wfe_go     = running & wfe_exec & !any_fault & !unstk_lock;
  wire evt_clr    = wfe_go & evt_latch;                                                 // [RQ12]

  cflsc_event_latch u_evt (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .set_evt (evt_set),
    .clr_evt (evt_clr),
    .latch_q (evt_latch)
  );

  // ------------------------------------------------------------
  // run-state next value
  // ------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    lock_fh_d = lock_fh_q;
    unique case (state_q)
      CFLSC_ST_RUN: begin
        if (enter_lock) begin
          state_d   = CFLSC_ST_LOCK;                                                    // [RQ1] [RQ5]
          lock_fh_d = fault_lock & (exec_ctx == CFLSC_CTX_FAULT);                       // [RQ7] [RQ8]
        end else if (fault_esc | nmi_go) begin
          state_d = CFLSC_ST_RUN;
        end else if (wfi_exec & !wake_exc) begin
          state_d = CFLSC_ST_SLPINT;                                                    // [RQ11]
        end else if (wfe_exec & !evt_latch) begin
          state_d = CFLSC_ST_SLPEVT;                                                    // [RQ12]
        end else if (ret_to_thread & sah_sel) begin
          state_d = CFLSC_ST_SLPINT;                                                    // [RQ14]
        end
      end
      CFLSC_ST_SLPINT: begin
        if (wake_exc) begin
          state_d = CFLSC_ST_RUN;                                                       // [RQ15]
        end
      end
      CFLSC_ST_SLPEVT: begin
        if (wake_evt) begin
          state_d = CFLSC_ST_RUN;                                                       // [RQ17] [RQ18]
        end
      end
      CFLSC_ST_LOCK: begin
        if (exit_lock) begin
          state_d   = CFLSC_ST_RUN;                                                     // [RQ7]
          lock_fh_d = 1'b0;
        end
      end
    endcase
  end

  wire slp_d    = (state_d == CFLSC_ST_SLPINT) | (state_d == CFLSC_ST_SLPEVT);
  wire wake_d   = !running & !in_lock & (state_d == CFLSC_ST_RUN);
  wire irq_go_d = irq_go_ok & running & (state_d == CFLSC_ST_RUN) & !fault_esc & !nmi_go;

  // run state and indicators
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= CFLSC_ST_RUN;
      lock_fh_q    <= 1'b0;
      core_run_q   <= 1'b1;
      lockup_q     <= 1'b0;
      sleeping_q   <= 1'b0;
      deep_sleep_q <= 1'b0;
      wake_q       <= 1'b0;
    end else begin
      state_q      <= state_d;
      lock_fh_q    <= lock_fh_d;
      core_run_q   <= (state_d == CFLSC_ST_RUN);                                        // [RQ6]
      lockup_q     <= (state_d == CFLSC_ST_LOCK);                                       // [RQ22]
      sleeping_q   <= slp_d;                                                            // [RQ9] [RQ22]
      deep_sleep_q <= slp_d & ds_sel;                                                   // [RQ9] [RQ10]
      wake_q       <= wake_d;
    end
  end

  // exception take pulses
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fault_take_q <= 1'b0;
      nmi_take_q   <= 1'b0;
      irq_take_q   <= 1'b0;
    end else begin
      fault_take_q <= fault_esc;                                                        // [RQ1]
      nmi_take_q   <= nmi_go;                                                           // [RQ4]
      irq_take_q   <= irq_go_d;                                                         // [RQ16] [RQ21]
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  wire aw_hs    = s_axi_awvalid & s_axi_awready;
  wire w_hs     = s_axi_wvalid & s_axi_wready;
  wire wr_go    = aw_got_q & w_got_q & !s_axi_bvalid;
  wire wr_ctrl  = wr_go & (awaddr_q == CFLSC_CTRL_OFS);
  wire wr_ok    = wr_ctrl | (awaddr_q == CFLSC_STAT_OFS);

  // address and data capture in either order
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_got_q <= 1'b0;
      end
      if (w_hs) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_got_q <= 1'b0;
      end
    end
  end

  // readies and write response
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CFLSC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_q & !aw_hs & !s_axi_bvalid;
      s_axi_wready  <= !w_got_q & !w_hs & !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? CFLSC_RESP_OKAY : CFLSC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register, low byte lane only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CFLSC_CTRL_RST;
    end else if (wr_ctrl & wstrb_q[0]) begin
      ctrl_q <= wdata_q[3:0];                                                           // [RQ10]
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  wire        ar_hs   = s_axi_arvalid & s_axi_arready;
  wire [3:0]  stat_w  = {lock_fh_q, deep_sleep_q, sleeping_q, lockup_q};                // [RQ22]
  wire        rd_ctrl = (s_axi_araddr == CFLSC_CTRL_OFS);
  wire        rd_stat = (s_axi_araddr == CFLSC_STAT_OFS);
  wire [31:0] rd_data = rd_ctrl ? {28'h0000000, ctrl_q} :
                        rd_stat ? {28'h0000000, stat_w} : 32'h0000_0000;

  // read channel, one read at a time
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CFLSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid & !ar_hs;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= (rd_ctrl | rd_stat) ? CFLSC_RESP_OKAY : CFLSC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : cflsc_top
`default_nettype wire
